// ### hw/len_field_codec.sv
// Length field encoder and decoder for one line unit
`timescale 1ns/1ns
`include "pkt_engine_cfg.svh"
module len_field_codec (
  // Field format
  input  wire logic                   i_ascii,
  input  wire logic [2:0]             i_nbytes,
  input  wire pkt_engine_pkg::order_t i_order,
  input  wire logic [1:0]             i_pos,
  // Send side
  input  wire logic [31:0]            i_value,
  output logic      [7:0]             o_tx_byte,
  // Receive side
  input  wire logic [7:0]             i_rx_byte,
  output logic      [31:0]            o_rx_word,
  output logic                        o_rx_ok,
  output logic      [31:0]            o_mask
);
  import pkt_engine_pkg::*;

  logic [1:0]  unit_idx;
  logic [4:0]  sh;
  logic [5:0]  bits;
  logic [31:0] shifted;
  logic [3:0]  nib;
  logic [3:0]  dig;

  always_comb begin
    case (i_order)
      ORD_REV:  unit_idx = i_pos;
      ORD_SWAP: unit_idx = i_pos ^ 2'h2;
      default:  unit_idx = 2'(i_nbytes - 3'h1) - i_pos;
    endcase
  end

  assign sh      = i_ascii ? {1'b0, unit_idx, 2'h0} : {unit_idx, 3'h0};
  assign bits    = i_ascii ? {1'b0, i_nbytes, 2'h0} : {i_nbytes, 3'h0};
  // Units beyond the field width are simply never emitted
  assign o_mask  = ~(32'hFFFF_FFFF << bits);
  assign shifted = i_value >> sh;
  assign nib     = shifted[3:0];

  always_comb begin
    if (!i_ascii) begin
      o_tx_byte = shifted[7:0];
    end else if (nib < 4'hA) begin
      o_tx_byte = `CH_0 + {4'h0, nib};
    end else begin
      o_tx_byte = `CH_UA_OFS + {4'h0, nib};
    end
  end

  always_comb begin
    o_rx_ok = 1'b1;
    dig     = 4'h0;
    if (i_rx_byte >= `CH_0 && i_rx_byte <= `CH_9) begin
      dig = 4'(i_rx_byte - `CH_0);
    end else if (i_rx_byte >= `CH_UA && i_rx_byte <= `CH_UF) begin
      dig = 4'(i_rx_byte - `CH_UA_OFS);
    end else if (i_rx_byte >= `CH_LA && i_rx_byte <= `CH_LF) begin
      dig = 4'(i_rx_byte - `CH_LA_OFS);
    end else begin
      o_rx_ok = !i_ascii;
    end
    o_rx_word = (i_ascii ? {28'h0, dig} : {24'h0, i_rx_byte}) << sh;
  end

endmodule // len_field_codec

// ### hw/pkt_engine.sv
// Packet builder and receive matcher driven by element definitions
// Overview of operation
// - Send-only: transmit packet once, then finish
// - Receive-only: accept packet matching any of up to sixteen
// - Send-receive: transmit, then match up to sixteen
// - At most 32 elements, 2046 data bytes
// - Static data sent as is, compared on receive
// - Static value 1..50 bytes, per-type byte range checked on send only
// - Several static elements anywhere in packet
// - Sending inserts computed range byte count
// - Receiving checks length field against range count
// - Length field 1..4 bytes, ASCII or binary
// - Forward order: most significant unit first
// - Reverse order: least first, not one byte
// - Word swap order only for four bytes
// - Range start and end indexes 1..32
// - Only length elements gives element error
// - Excess high-order digits of count dropped
// - Bad ASCII hex length character: no match
// - ASCII length sent with 0-9, A-F
`timescale 1ns/1ns
`include "pkt_engine_cfg.svh"
module pkt_engine #(
  parameter int POOL_DEPTH = 4096
) (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rstn,
  // Definition loading
  input  wire logic                   i_cnt_we,
  input  wire logic                   i_elem_we,
  input  wire logic [4:0]             i_cfg_def,
  input  wire logic [4:0]             i_cfg_elem,
  input  wire logic [5:0]             i_cfg_cnt,
  input  wire pkt_engine_pkg::elem_t  i_cfg_word,
  input  wire logic                   i_pool_we,
  input  wire logic [11:0]            i_pool_addr,
  input  wire logic [7:0]             i_pool_data,
  // Execution control
  input  wire logic                   i_start,
  input  wire pkt_engine_pkg::comm_t  i_comm,
  input  wire logic [4:0]             i_nrecv,
  output logic                        o_busy,
  output logic                        o_done,
  output logic                        o_err_elem,
  output logic                        o_matched,
  output logic      [3:0]             o_match_idx,
  // Send stream
  output logic                        o_tx_valid,
  output logic      [7:0]             o_tx_data,
  output logic                        o_tx_last,
  input  wire logic                   i_tx_ready,
  // Receive stream
  input  wire logic                   i_rx_valid,
  input  wire logic [7:0]             i_rx_data,
  input  wire logic                   i_rx_last,
  output logic                        o_rx_ready
);
  import pkt_engine_pkg::*;

  typedef struct packed {
    state_t      st;
    state_t      ret;
    comm_t       comm;
    logic [4:0]  nrecv;
    logic [4:0]  def;
    logic [5:0]  el;
    logic [5:0]  bi;
    logic [5:0]  k;
    logic [11:0] sum;
    logic        sv;
    logic        seen;
    logic        txing;
    logic        ovf;
    logic [10:0] pos;
    logic [10:0] rlen;
    logic [31:0] acc;
    logic        txv;
    logic [7:0]  txd;
    logic        txl;
    logic        done;
    logic        err;
    logic        matched;
    logic [3:0]  midx;
  } ctl_t;

  elem_t      elem_mem [0:`NDEF*`MAX_ELEM-1];
  logic [5:0] cnt_mem  [0:`NDEF-1];
  logic [7:0] pool_mem [0:POOL_DEPTH-1];
  logic [7:0] rx_mem   [0:`MAX_DATA-1];

  ctl_t        s_q;
  ctl_t        s_d;
  elem_t       cur;
  elem_t       calc;
  logic [5:0]  cnt;
  logic [7:0]  pbyte;
  logic [7:0]  rbyte;
  logic [7:0]  enc_byte;
  logic [31:0] dec_word;
  logic [31:0] mask;
  logic        dec_ok;
  logic        adv;
  logic        last_b;
  logic        last_e;
  logic        rx_take;
  logic        len_emit;

  function automatic logic [5:0] esize(elem_t e);
    esize = e.is_len ? {3'h0, e.nbytes} : e.len;
  endfunction

  function automatic logic elem_bad(elem_t e, logic [5:0] n);
    if (e.is_len) begin
      elem_bad = e.nbytes == 3'h0 || e.nbytes > `MAX_LEN_B
        || (e.order == ORD_REV && e.nbytes == 3'h1)
        || (e.order == ORD_SWAP && e.nbytes != `MAX_LEN_B)
        || e.rstart == 6'h0 || e.rend < e.rstart || e.rend > n;
    end else begin
      elem_bad = e.len == 6'h0 || e.len > `MAX_STATIC;
    end
  endfunction

  function automatic logic byte_ok(code_t c, logic [7:0] b);
    case (c)
      CODE_STR:  byte_ok = b >= `STR_LO && b <= `STR_HI;
      CODE_CTRL: byte_ok = b <= `CTRL_HI || b == `CTRL_DEL;
      CODE_HEX:  byte_ok = 1'b1;
      default:   byte_ok = 1'b0;
    endcase
  endfunction

  function automatic ctl_t step(ctl_t s, logic lb);
    step     = s;
    step.pos = s.pos + 11'h1;
    if (lb) begin
      step.bi  = 6'h0;
      step.el  = s.el + 6'h1;
      step.sv  = 1'b0;
      step.acc = 32'h0;
    end else begin
      step.bi = s.bi + 6'h1;
    end
  endfunction

  // Definition and data memories
  always_ff @(posedge i_ref_clk) begin
    if (i_elem_we) begin
      elem_mem[{i_cfg_def, i_cfg_elem}] <= i_cfg_word;
    end
    if (i_cnt_we) begin
      cnt_mem[i_cfg_def] <= i_cfg_cnt;
    end
    if (i_pool_we) begin
      pool_mem[i_pool_addr] <= i_pool_data;
    end
    if (rx_take) begin
      rx_mem[s_q.rlen] <= i_rx_data;
    end
  end

  assign cur    = elem_mem[{s_q.def, s_q.el[4:0]}];
  assign calc   = elem_mem[{s_q.def, s_q.k[4:0]}];
  assign cnt    = cnt_mem[s_q.def];
  assign pbyte  = pool_mem[12'(cur.ptr + {6'h0, s_q.bi})];
  assign rbyte  = rx_mem[s_q.pos];
  assign last_b = s_q.bi == esize(cur) - 6'h1;
  assign last_e = s_q.el == cnt - 6'h1;
  // Output byte register frees up when empty or being taken
  assign adv    = !s_q.txv || i_tx_ready;

  len_field_codec u_codec (
    .i_ascii   (cur.len_ascii),
    .i_nbytes  (cur.nbytes),
    .i_order   (cur.order),
    .i_pos     (s_q.bi[1:0]),
    .i_value   ({20'h0, s_q.sum}),
    .o_tx_byte (enc_byte),
    .i_rx_byte (rbyte),
    .o_rx_word (dec_word),
    .o_rx_ok   (dec_ok),
    .o_mask    (mask)
  );

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    rx_take  = 1'b0;
    if (adv) begin
      s_d.txv = 1'b0;
    end
    case (s_q.st)
      ST_IDLE: if (i_start) begin
        s_d.comm    = i_comm;
        s_d.nrecv   = i_nrecv;
        s_d.err     = 1'b0;
        s_d.matched = 1'b0;
        s_d.midx    = 4'h0;
        s_d.def     = 5'h0;
        s_d.el      = 6'h0;
        s_d.seen    = 1'b0;
        s_d.rlen    = 11'h0;
        s_d.ovf     = 1'b0;
        s_d.txing   = i_comm != COMM_RECV;
        if (i_comm != COMM_SEND && (i_nrecv == 5'h0 || i_nrecv > `MAX_RECV)) begin
          s_d.st = ST_FAIL;
        end else begin
          s_d.st = (i_comm == COMM_RECV) ? ST_RXCAP : ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (cnt == 6'h0 || cnt > `MAX_ELEM) begin
          s_d.st = ST_FAIL;
        end else if (s_q.el == cnt) begin
          s_d.el  = 6'h0;
          s_d.bi  = 6'h0;
          s_d.pos = 11'h0;
          s_d.sv  = 1'b0;
          s_d.acc = 32'h0;
          s_d.st  = !s_q.seen ? ST_FAIL : s_q.txing ? ST_SEND : ST_MATCH;
        end else if (elem_bad(cur, cnt)) begin
          s_d.st = ST_FAIL;
        end else begin
          s_d.seen = s_q.seen | !cur.is_len;
          s_d.el   = s_q.el + 6'h1;
        end
      end
      ST_CALC: begin
        s_d.sum = s_q.sum + {6'h0, esize(calc)};
        s_d.k   = s_q.k + 6'h1;
        if (s_q.k == cur.rend - 6'h1) begin
          s_d.sv = 1'b1;
          s_d.st = s_q.ret;
        end
      end
      ST_SEND: begin
        if (cur.is_len && !s_q.sv) begin
          s_d.k   = cur.rstart - 6'h1;
          s_d.sum = 12'h0;
          s_d.ret = ST_SEND;
          s_d.st  = ST_CALC;
        end else if (adv) begin
          if (s_q.pos == `MAX_DATA) begin
            s_d.st = ST_FAIL;
          end else if (!cur.is_len && !byte_ok(cur.code, pbyte)) begin
            s_d.st = ST_FAIL;
          end else begin
            s_d     = step(s_q, last_b);
            s_d.txv = 1'b1;
            // Codec emits only the low units that fit the field
            s_d.txd = cur.is_len ? enc_byte : pbyte;
            s_d.txl = last_b && last_e;
            if (last_b && last_e) begin
              s_d.st = ST_DRAIN;
            end
          end
        end
      end
      ST_DRAIN: if (adv) begin
        if (s_q.comm == COMM_SEND) begin
          s_d.done = 1'b1;
          s_d.st   = ST_IDLE;
        end else begin
          s_d.txing = 1'b0;
          s_d.rlen  = 11'h0;
          s_d.st    = ST_RXCAP;
        end
      end
      ST_RXCAP: if (i_rx_valid) begin
        if (s_q.rlen == `MAX_DATA) begin
          s_d.ovf = 1'b1;
        end else begin
          rx_take  = 1'b1;
          s_d.rlen = s_q.rlen + 11'h1;
        end
        if (i_rx_last) begin
          s_d.ovf = 1'b0;
          if (s_q.ovf || s_q.rlen == `MAX_DATA) begin
            s_d.rlen = 11'h0;
          end else begin
            s_d.def  = 5'h1;
            s_d.el   = 6'h0;
            s_d.seen = 1'b0;
            s_d.st   = ST_SCAN;
          end
        end
      end
      ST_MATCH: begin
        if (s_q.el == cnt) begin
          if (s_q.pos == s_q.rlen) begin
            s_d.matched = 1'b1;
            s_d.midx    = 4'(s_q.def - 5'h1);
            s_d.done    = 1'b1;
            s_d.st      = ST_IDLE;
          end else begin
            s_d.st = ST_NEXT;
          end
        end else if (cur.is_len && !s_q.sv) begin
          s_d.k   = cur.rstart - 6'h1;
          s_d.sum = 12'h0;
          s_d.ret = ST_MATCH;
          s_d.st  = ST_CALC;
        end else if (s_q.pos == s_q.rlen) begin
          s_d.st = ST_NEXT;
        end else if (!cur.is_len) begin
          if (rbyte != pbyte) begin
            s_d.st = ST_NEXT;
          end else begin
            s_d = step(s_q, last_b);
          end
        end else if (!dec_ok) begin
          s_d.st = ST_NEXT;
        end else if (last_b && (s_q.acc | dec_word) != ({20'h0, s_q.sum} & mask)) begin
          s_d.st = ST_NEXT;
        end else begin
          s_d = step(s_q, last_b);
          if (!last_b) begin
            s_d.acc = s_q.acc | dec_word;
          end
        end
      end
      ST_NEXT: begin
        if (s_q.def == s_q.nrecv) begin
          s_d.rlen = 11'h0;
          s_d.st   = ST_RXCAP;
        end else begin
          s_d.def  = s_q.def + 5'h1;
          s_d.el   = 6'h0;
          s_d.seen = 1'b0;
          s_d.st   = ST_SCAN;
        end
      end
      ST_FAIL: begin
        s_d.err  = 1'b1;
        s_d.done = 1'b1;
        s_d.st   = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy      = s_q.st != ST_IDLE;
  assign o_done      = s_q.done;
  assign o_err_elem  = s_q.err;
  assign o_matched   = s_q.matched;
  assign o_match_idx = s_q.midx;
  assign o_tx_valid  = s_q.txv;
  assign o_tx_data   = s_q.txd;
  assign o_tx_last   = s_q.txl;
  assign o_rx_ready  = s_q.st == ST_RXCAP;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  // Length unit about to enter the output byte register
  assign len_emit = s_q.st == ST_SEND && adv && cur.is_len && s_q.sv && s_q.pos != `MAX_DATA;

  send_once_a: assert property (
    s_q.st == ST_DRAIN && adv && s_q.comm == COMM_SEND
    |=> o_done && !o_busy ##1 !o_tx_valid && !o_busy)
    else $error("send-only did not finish after one packet");
  match_range_a: assert property (
    o_done && o_matched |-> {1'b0, o_match_idx} < s_q.nrecv)
    else $error("matched index beyond configured definitions");
  send_rx_a: assert property (
    s_q.st == ST_DRAIN && adv && s_q.comm == COMM_SEND_RECV |=> o_rx_ready && !o_done)
    else $error("receive phase did not follow the send");
  data_cap_a: assert property (
    s_q.pos <= `MAX_DATA && s_q.rlen <= `MAX_DATA)
    else $error("packet data exceeded limit");
  static_tx_a: assert property (
    s_q.st == ST_SEND && adv && !cur.is_len && s_d.st != ST_FAIL
    |=> o_tx_valid && o_tx_data == $past(pbyte))
    else $error("static byte not sent as configured");
  fwd_msb_a: assert property (
    len_emit && (!cur.len_ascii && cur.order == ORD_FWD && cur.nbytes == 3'h2
    && s_q.bi == 6'h0) |=> o_tx_data == 8'($past(s_q.sum) >> 8))
    else $error("forward length not upper byte first");
  rev_lsb_a: assert property (
    len_emit && (!cur.len_ascii && cur.order == ORD_REV && s_q.bi == 6'h0)
    |=> o_tx_data == 8'($past(s_q.sum)))
    else $error("reverse length not lower byte first");
  swap_word_a: assert property (
    len_emit && (!cur.len_ascii && cur.order == ORD_SWAP && s_q.bi == 6'h2)
    |=> o_tx_data == 8'($past(s_q.sum)))
    else $error("word swap placed low byte wrongly");
  len_only_a: assert property (
    s_q.st == ST_SCAN && cnt != 6'h0 && cnt <= `MAX_ELEM && s_q.el == cnt && !s_q.seen
    |=> s_q.st == ST_FAIL ##1 o_err_elem && o_done)
    else $error("length-only packet not flagged");
  trunc_a: assert property (
    len_emit && (!cur.len_ascii && cur.nbytes == 3'h1)
    |=> o_tx_data == 8'($past(s_q.sum)))
    else $error("one-byte length not truncated to low byte");
  ascii_bad_a: assert property (
    s_q.st == ST_MATCH && cur.is_len && cur.len_ascii && s_q.sv && s_q.el != cnt
    && s_q.pos != s_q.rlen && !dec_ok |=> s_q.st == ST_NEXT)
    else $error("bad hex character did not reject definition");
  ascii_tx_a: assert property (
    len_emit && cur.len_ascii
    |=> o_tx_data inside {[`CH_0:`CH_9], [`CH_UA:`CH_UF]})
    else $error("ASCII length character out of set");

  send_done_c:  cover property (s_q.st == ST_DRAIN && adv && s_q.comm == COMM_SEND);
  match_c:      cover property (o_done && o_matched && o_match_idx != 4'h0);
  elem_err_c:   cover property (o_done && o_err_elem);
  ascii_len_c:  cover property (len_emit && cur.len_ascii);

endmodule // pkt_engine

// ### hw/pkt_engine_cfg.svh
// Limits and character codes for the packet engine
`ifndef PKT_ENGINE_CFG_SVH
`define PKT_ENGINE_CFG_SVH

`define NDEF        17
`define MAX_ELEM    6'h20
`define MAX_DATA    11'h7FE
`define MAX_RECV    5'h10
`define MAX_STATIC  6'h32
`define MAX_LEN_B   3'h4
`define STR_LO      8'h20
`define STR_HI      8'h7F
`define CTRL_HI     8'h1F
`define CTRL_DEL    8'h7F
`define CH_0        8'h30
`define CH_9        8'h39
`define CH_UA       8'h41
`define CH_UF       8'h46
`define CH_LA       8'h61
`define CH_LF       8'h66
`define CH_UA_OFS   8'h37
`define CH_LA_OFS   8'h57

`endif

// ### hw/pkt_engine_pkg.sv
// Types shared by the packet engine
package pkt_engine_pkg;

  typedef enum logic [1:0] {COMM_SEND, COMM_RECV, COMM_SEND_RECV} comm_t;
  typedef enum logic [1:0] {CODE_STR, CODE_CTRL, CODE_HEX} code_t;
  typedef enum logic [1:0] {ORD_FWD, ORD_REV, ORD_SWAP} order_t;

  typedef struct packed {
    logic        is_len;
    code_t       code;
    logic        len_ascii;
    logic [11:0] ptr;
    logic [5:0]  len;
    logic [2:0]  nbytes;
    order_t      order;
    logic [5:0]  rstart;
    logic [5:0]  rend;
  } elem_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SCAN, ST_SEND, ST_CALC, ST_DRAIN,
    ST_RXCAP, ST_MATCH, ST_NEXT, ST_FAIL
  } state_t;

endpackage

// ### test/pkt_engine_test.sv
// Self-checking bench for the packet engine
`timescale 1ns/1ns
module pkt_engine_test;
  import pkt_engine_pkg::*;
  logic        clk, rstn, cnt_we, elem_we, pool_we, start, slow;
  logic        busy, done, err, matched, txv, txl, txr, rxv, rxl, rxr;
  logic [4:0]  cdef, celem, nrecv;
  logic [5:0]  ccnt;
  logic [11:0] paddr;
  logic [7:0]  pdata, txd, rxd;
  logic [3:0]  idx;
  elem_t       cword, e0, e1;
  comm_t       comm;
  logic [7:0]  pool_b [0:127];
  logic [7:0]  exp_q [$];
  int          fail_count, check_count, seed, len, c;

  pkt_engine dut (.i_ref_clk(clk), .i_rstn(rstn), .i_cnt_we(cnt_we), .i_elem_we(elem_we),
    .i_cfg_def(cdef), .i_cfg_elem(celem), .i_cfg_cnt(ccnt), .i_cfg_word(cword),
    .i_pool_we(pool_we), .i_pool_addr(paddr), .i_pool_data(pdata), .i_start(start),
    .i_comm(comm), .i_nrecv(nrecv), .o_busy(busy), .o_done(done), .o_err_elem(err),
    .o_matched(matched), .o_match_idx(idx), .o_tx_valid(txv), .o_tx_data(txd),
    .o_tx_last(txl), .i_tx_ready(txr), .i_rx_valid(rxv), .i_rx_data(rxd),
    .i_rx_last(rxl), .o_rx_ready(rxr));
  pkt_peer peer (.i_ref_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_tx_valid(txv),
    .i_tx_data(txd), .i_tx_last(txl), .o_tx_ready(txr), .o_rx_valid(rxv), .o_rx_data(rxd),
    .o_rx_last(rxl), .i_rx_ready(rxr));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  function automatic elem_t st(input code_t k, input logic [11:0] p, input logic [5:0] l);
    return '{is_len: 1'b0, code: k, len_ascii: 1'b0, ptr: p, len: l, nbytes: 3'h1,
             order: ORD_FWD, rstart: 6'h01, rend: 6'h01};
  endfunction

  function automatic elem_t ln(input logic a, input logic [2:0] n, input order_t o,
                               input logic [5:0] rs, input logic [5:0] re);
    return '{is_len: 1'b1, code: CODE_HEX, len_ascii: a, ptr: 12'h000, len: 6'h00,
             nbytes: n, order: o, rstart: rs, rend: re};
  endfunction

  // One line unit of a length value, unit 0 least significant
  function automatic logic [7:0] unit(input logic [31:0] v, input int i, input logic a);
    logic [3:0] d;
    d = v[4*i +: 4];
    if (!a) return v[8*i +: 8];
    return (d < 10) ? 8'h30 + d : 8'h37 + d;
  endfunction

  function automatic int pos_of(input int k, input int n, input order_t o);
    if (o == ORD_FWD) return n - 1 - k;
    if (o == ORD_REV) return k;
    return k ^ 2;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr_pool(input logic [11:0] a, input logic [7:0] v);
    @(negedge clk);
    pool_we = 1;
    paddr = a;
    pdata = v;
    pool_b[a[6:0]] = v;
  endtask

  task automatic wr_def(input logic [4:0] d, input int n, input elem_t w0, w1, w2);
    elem_t e [3];
    e = '{w0, w1, w2};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      pool_we = 0;
      cnt_we = 1;
      elem_we = 1;
      cdef = d;
      ccnt = 6'(n);
      celem = 5'(i);
      cword = e[i];
    end
    @(negedge clk);
    cnt_we = 0;
    elem_we = 0;
  endtask

  task automatic run(input comm_t k, input logic [4:0] nr);
    int t;
    @(negedge clk);
    pool_we = 0;
    start = 1;
    comm = k;
    nrecv = nr;
    @(negedge clk);
    start = 0;
    t = 0;
    while (done !== 1'b1 && t < 4000) begin
      @(posedge clk);
      #1;
      t++;
    end
    chk(t < 4000, 1, "done pulse");
  endtask

  task automatic cmp_tx();
    chk(peer.tx_q.size(), exp_q.size(), "send count");
    foreach (exp_q[i]) begin
      chk(peer.tx_q[i], exp_q[i], "send byte");
      chk(peer.tx_lq[i], i == exp_q.size() - 1, "last flag");
    end
    peer.tx_q.delete();
    peer.tx_lq.delete();
  endtask

  // Receive packet body: byte 0x51, count field "0" then lc, ten counted bytes; matches only with lc 'A' or 'a'
  task automatic put_rx(input logic [7:0] lc);
    logic [7:0] b [$];
    b = '{8'h51, 8'h30, lc};
    for (int i = 0; i < 10; i++) b.push_back(pool_b[66 + i]);
    foreach (b[i]) peer.rx_q.push_back({i == b.size() - 1, b[i]});
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    {rstn, cnt_we, elem_we, pool_we, start, slow} = '0;
    {cdef, celem, nrecv, ccnt, paddr, pdata} = '0;
    seed = 91329;
    fail_count = 0;
    check_count = 0;
    cword = '0;
    comm = COMM_SEND;
    repeat (8) @(negedge clk);
    rstn = 1;
    chk(busy, 0, "busy after reset");
    wr_pool(12'h040, 8'h5A);
    for (int a = 0; a < 2; a++)
      for (int n = 1; n <= 4; n++)
        for (int o = 0; o < 3; o++) begin
          if ((o == 1 && n == 1) || (o == 2 && n != 4)) continue;
          len = (a == 1 && n == 1) ? 50 : 1 + {$random(seed)} % 50;
          slow = 1'($random(seed));
          exp_q.delete();
          for (int i = 0; i < len; i++) begin
            wr_pool(12'(i), 8'($random(seed)));
            exp_q.push_back(pool_b[i]);
          end
          for (int k = 0; k < n; k++) exp_q.push_back(unit(len, pos_of(k, n, order_t'(o)), a[0]));
          exp_q.push_back(8'h5A);
          wr_def(0, 3, st(CODE_HEX, 12'h000, 6'(len)), ln(a[0], 3'(n), order_t'(o), 1, 1),
                 st(CODE_STR, 12'h040, 6'h01));
          run(COMM_SEND, 5'h01);
          cmp_tx();
          chk(err, 0, "send error flag");
        end
    $display("test send done");
    for (int i = 0; i < 10; i++) wr_pool(12'h042 + 12'(i), 8'($random(seed)));
    wr_pool(12'h041, 8'h51);
    wr_pool(12'h04C, 8'h10);
    wr_pool(12'h04D, 8'h52);
    e0 = st(CODE_HEX, 12'h041, 6'h01);
    e1 = ln(1'b1, 3'h2, ORD_FWD, 6'h03, 6'h03);
    wr_def(1, 3, e0, e1, st(CODE_HEX, 12'h042, 6'h0A));
    wr_def(2, 1, st(CODE_HEX, 12'h04D, 6'h01), '0, '0);
    wr_def(3, 3, e0, e1, st(CODE_HEX, 12'h042, 6'h0A));
    put_rx(8'h42);
    put_rx(8'h67);
    put_rx(8'h61);
    run(COMM_RECV, 5'h03);
    chk(matched, 1, "match flag");
    chk(idx, 0, "match index");
    chk(peer.rx_q.size(), 0, "packets consumed");
    $display("test receive done");
    peer.rx_q.push_back({1'b1, 8'h52});
    run(COMM_SEND_RECV, 5'h03);
    cmp_tx();
    chk(matched, 1, "send receive match");
    chk(idx, 1, "send receive index");
    $display("test send receive done");
    for (int k = 0; k < 10; k++) begin
      e0 = st(CODE_HEX, 12'h000, 6'h04);
      e1 = ln(1'b0, 3'h2, ORD_FWD, 6'h01, 6'h01);
      c = 3;
      case (k)
        0: begin
          c = 1;
          e0 = ln(1'b0, 3'h1, ORD_FWD, 6'h01, 6'h01);
        end
        1: e1 = ln(1'b0, 3'h1, ORD_REV, 6'h01, 6'h01);
        2: e1 = ln(1'b0, 3'h2, ORD_SWAP, 6'h01, 6'h01);
        3: e1.rend = 6'h04;
        4: e0.len = 6'h33;
        5: e0 = st(CODE_STR, 12'h04C, 6'h01);
        6: c = 33;
        9: e0 = st(CODE_CTRL, 12'h04D, 6'h01);
        default: c = 3;
      endcase
      wr_def(0, c, e0, e1, st(CODE_STR, 12'h040, 6'h01));
      run((k == 7 || k == 8) ? COMM_RECV : COMM_SEND,
          k == 7 ? 5'h00 : (k == 8 ? 5'h11 : 5'h01));
      chk(err, 1, "element error");
      chk(matched, 0, "no match on error");
      peer.tx_q.delete();
      peer.tx_lq.delete();
    end
    $display("test errors done");
    report_and_stop();
  end
endmodule // pkt_engine_test

// ### test/pkt_peer.sv
// Connected device model: takes send bytes, replays queued receive packets
`timescale 1ns/1ns
module pkt_peer (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // Random stalls on the send side
  input  wire logic       i_slow,
  // Send stream from the engine
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  input  wire logic       i_tx_last,
  output logic            o_tx_ready,
  // Receive stream into the engine
  output logic            o_rx_valid,
  output logic      [7:0] o_rx_data,
  output logic            o_rx_last,
  input  wire logic       i_rx_ready
);
  logic [7:0] tx_q [$];
  logic       tx_lq [$];
  logic [8:0] rx_q [$];
  int         seed;

  initial begin
    seed = 91329;
    o_tx_ready = 0;
    o_rx_valid = 0;
    o_rx_data = 8'hFF;
    o_rx_last = 0;
  end

  always @(posedge i_ref_clk) begin
    if (i_rstn && i_tx_valid && o_tx_ready) begin
      tx_q.push_back(i_tx_data);
      tx_lq.push_back(i_tx_last);
    end
    if (i_rstn && o_rx_valid && i_rx_ready) begin
      rx_q.delete(0);
    end
  end

  // Front byte held until taken; released data line toggles
  always @(negedge i_ref_clk) begin
    o_tx_ready <= !i_slow || ({$random(seed)} % 3 == 0);
    if (rx_q.size() != 0) begin
      o_rx_valid <= 1;
      o_rx_data <= rx_q[0][7:0];
      o_rx_last <= rx_q[0][8];
    end else begin
      o_rx_valid <= 0;
      o_rx_data <= ~o_rx_data;
      o_rx_last <= 0;
    end
  end
endmodule // pkt_peer
